/* File: hw/atcu_cfg.svh */
// constants for the analog threshold compare unit
// assumes inclusion by the top module and the bench, by bare name
// How it works
// - actual value is raw input times gain plus zero offset
// - zero to ten volts maps to internal value zero to 1000
// - set at or above clear: high above set, low at or below clear
// - set below clear: high while set <= value < clear
// - differential mode: clear threshold is set plus signed differential
// - negative differential gives hysteresis behaviour
// - positive differential gives window behaviour
// - comparator mode decides on first minus second scaled input
// - both inputs share gain and offset; hysteresis or window on difference
// - comparator hysteresis clears at or below clear threshold
// - decimal places ignored in compare; only raw integers compared
`ifndef ATCU_CFG_SVH
`define ATCU_CFG_SVH
// ***************************************************
// register map, byte addresses
// ***************************************************
`define ATCU_OFF_CTRL 12'h000
`define ATCU_OFF_GAIN 12'h004
`define ATCU_OFF_ZERO 12'h008
`define ATCU_OFF_SET 12'h00C
`define ATCU_OFF_CLR 12'h010
`define ATCU_OFF_DIFF 12'h014
`define ATCU_OFF_STAT 12'h018
// ***************************************************
// fields and reset values
// ***************************************************
`define ATCU_MODE_LSB 0
`define ATCU_MODE_MSB 1
`define ATCU_DEC_LSB 4
`define ATCU_DEC_MSB 5
`define ATCU_GAIN_RST 32'h0000_0064
`define ATCU_GAIN_SCALE 32'h0000_0064
`define ATCU_FULL_SCALE 32'h0000_03E8
`define ATCU_CYCLE_DIV 16'h9C40
`define ATCU_MODE_RST 2'h0
`define ATCU_DEC_RST 2'h0
`define ATCU_REG_RST 32'h0000_0000
`define ATCU_STAT_TRIG 0
`endif

/* File: hw/atcu_pkg.sv */
// types for the analog threshold compare unit
// assumes atcu_cfg.svh holds all numbers
package atcu_pkg;
  // ***************************************************
  // modes
  // ***************************************************
  typedef enum logic [1:0] {
    ATCU_THRESH,
    ATCU_DIFFER,
    ATCU_COMPARE,
    ATCU_SPARE
  } atcu_mode_t;
endpackage : atcu_pkg

/* File: hw/atcu_top.sv */
// analog threshold compare unit with apb register slave
// assumes synchronous inputs and a single 40 MHz pclk
`timescale 1ns/10ps
`include "atcu_cfg.svh"
module atcu_top #(
  parameter int unsigned CYCLE_DIV = `ATCU_CYCLE_DIV,
  parameter int unsigned AW = 11
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog values from other blocks, internal scale 0..1000
  input wire logic [AW-1:0] first_analog_input,
  input wire logic [AW-1:0] second_analog_input,
  // trigger output and evaluation strobe
  output logic trig_out,
  output logic eval_strobe
);
  // ***************************************************
  // configuration registers
  // ***************************************************
  logic [1:0] mode;
  logic [1:0] dec_places;
  logic [31:0] gain;
  logic [31:0] zero_off;
  logic [31:0] set_thr;
  logic [31:0] clr_thr;
  logic [31:0] diff_val;
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // software writes; decimal places kept only for readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `ATCU_MODE_RST;
      dec_places <= `ATCU_DEC_RST;
      gain <= `ATCU_GAIN_RST;
      zero_off <= `ATCU_REG_RST;
      set_thr <= `ATCU_REG_RST;
      clr_thr <= `ATCU_REG_RST;
      diff_val <= `ATCU_REG_RST;
    end else if (wr_en) begin
      case (paddr)
        `ATCU_OFF_CTRL: begin
          mode <= pwdata[`ATCU_MODE_MSB:`ATCU_MODE_LSB];
          dec_places <= pwdata[`ATCU_DEC_MSB:`ATCU_DEC_LSB];
        end
        `ATCU_OFF_GAIN: gain <= pwdata;
        `ATCU_OFF_ZERO: zero_off <= pwdata;
        `ATCU_OFF_SET: set_thr <= pwdata;
        `ATCU_OFF_CLR: clr_thr <= pwdata;
        `ATCU_OFF_DIFF: diff_val <= pwdata;
        default: begin
        end
      endcase
    end
  end

  // read mux decoded in setup so data stands in access phase
  logic [31:0] next_prdata;
  logic bad_addr;
  always_comb begin
    next_prdata = 32'h0000_0000;
    bad_addr = 1'b0;
    case (paddr)
      `ATCU_OFF_CTRL: begin
        next_prdata[`ATCU_MODE_MSB:`ATCU_MODE_LSB] = mode;
        next_prdata[`ATCU_DEC_MSB:`ATCU_DEC_LSB] = dec_places;
      end
      `ATCU_OFF_GAIN: next_prdata = gain;
      `ATCU_OFF_ZERO: next_prdata = zero_off;
      `ATCU_OFF_SET: next_prdata = set_thr;
      `ATCU_OFF_CLR: next_prdata = clr_thr;
      `ATCU_OFF_DIFF: next_prdata = diff_val;
      `ATCU_OFF_STAT: next_prdata[`ATCU_STAT_TRIG] = trig_out;
      default: bad_addr = 1'b1;
    endcase
  end

  // single wait-free access phase; slverr on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `ATCU_REG_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && bad_addr;
      if (rd_en) begin
        prdata <= next_prdata;
      end
    end
  end

  // ***************************************************
  // program cycle divider
  // ***************************************************
  logic [15:0] div_cnt;
  logic tick;
  assign tick = (div_cnt == 16'(CYCLE_DIV - 1));
  // one evaluation enable per program cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
    end else if (tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // ***************************************************
  // scaling and decision
  // ***************************************************
  // gain is hundredths; 64-bit math avoids overflow at extreme gain
  function automatic logic signed [63:0] scale(input logic [AW-1:0] raw);
    logic signed [63:0] prod;
    prod = 64'($signed({1'b0, raw})) * 64'($signed(gain));
    scale = prod / 64'($signed(`ATCU_GAIN_SCALE))
      + 64'($signed(zero_off));
  endfunction : scale

  logic signed [63:0] act_x;
  logic signed [63:0] act_y;
  logic signed [63:0] value;
  logic signed [63:0] on_t;
  logic signed [63:0] off_t;
  logic next_trig;
  always_comb begin
    act_x = scale(first_analog_input);
    act_y = scale(second_analog_input);
    on_t = 64'($signed(set_thr));
    off_t = 64'($signed(clr_thr));
    value = act_x;
    case (atcu_pkg::atcu_mode_t'(mode))
      atcu_pkg::ATCU_DIFFER:
        off_t = on_t + 64'($signed(diff_val));
      atcu_pkg::ATCU_COMPARE:
        value = act_x - act_y;
      default: begin
      end
    endcase
    // raw integer compare, decimal setting unused
    if (on_t >= off_t) begin
      // hysteresis
      if (value > on_t) begin
        next_trig = 1'b1;
      end else if (value <= off_t) begin
        next_trig = 1'b0;
      end else begin
        next_trig = trig_out;
      end
    end else begin
      // window; outside gives low
      next_trig = (value >= on_t) && (value < off_t);
    end
  end

  // output and cycle strobe registered on the evaluation tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_out <= 1'b0;
      eval_strobe <= 1'b0;
    end else begin
      eval_strobe <= tick;
      if (tick) begin
        trig_out <= next_trig;
      end
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  // steps that one evaluation may take
  sequence set_seen;
    tick && (on_t >= off_t) && (value > on_t);
  endsequence

  sequence clear_seen;
    tick && (on_t >= off_t) && (value <= off_t);
  endsequence

  // hysteresis: set above, clear at or below, hold between
  hyst_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    set_seen |=> trig_out)
    else $error("hysteresis set missed");
  hyst_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_seen |=> !trig_out)
    else $error("hysteresis clear missed");
  hyst_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && (on_t >= off_t) && (value <= on_t) && (value > off_t)
    |=> $stable(trig_out))
    else $error("hysteresis hold broken");
  // window: inside high, outside low
  window_in_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && (on_t < off_t) && (value >= on_t) && (value < off_t)
    |=> trig_out)
    else $error("window high missed");
  window_out_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && (on_t < off_t) && ((value < on_t) || (value >= off_t))
    |=> !trig_out)
    else $error("window low missed");
  // differential: checked against the registers, not the mux
  diff_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode == 2'h1
    |-> off_t == 64'($signed(set_thr)) + 64'($signed(diff_val)))
    else $error("derived clear wrong");
  diff_neg_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && mode == 2'h1 && diff_val[31]
    && (value <= 64'($signed(set_thr)) + 64'($signed(diff_val)))
    |=> !trig_out)
    else $error("negative differential clear missed");
  diff_pos_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && mode == 2'h1 && !diff_val[31] && diff_val != 32'h0
    && (value == on_t) |=> trig_out)
    else $error("positive differential window");
  // comparator: unit gain gives the bare difference of the inputs
  cmp_value_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    mode == 2'h2 && gain == `ATCU_GAIN_SCALE && zero_off == 32'h0
    |-> value == 64'(first_analog_input) - 64'(second_analog_input))
    else $error("comparator difference wrong");
  cmp_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && mode == 2'h2 && ($signed(set_thr) >= $signed(clr_thr))
    && (act_x - act_y <= 64'($signed(clr_thr)))
    |=> !trig_out)
    else $error("comparator clear missed");
  cmp_window_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && mode == 2'h2 && ($signed(set_thr) < $signed(clr_thr))
    && (act_x - act_y >= 64'($signed(set_thr)))
    && (act_x - act_y < 64'($signed(clr_thr)))
    |=> trig_out)
    else $error("comparator window missed");
  // evaluation cadence; pulse check needs a divider of two or more
  only_tick_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(tick) |-> $stable(trig_out))
    else $error("output changed off cycle");
  strobe_after_tick_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick |=> eval_strobe)
    else $error("strobe missing after tick");
  strobe_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    eval_strobe |=> !eval_strobe)
    else $error("strobe longer than one cycle");
  div_range_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    div_cnt < 16'(CYCLE_DIV))
    else $error("divider out of range");
  scale_unit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    gain == `ATCU_GAIN_SCALE && zero_off == 32'h0
    |-> act_x == 64'(first_analog_input))
    else $error("unit gain scale wrong");
  // raw compare whatever the decimal field says
  dec_ignored_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && (dec_places != 2'h0) && (on_t < off_t)
    |=> trig_out == (($past(value) >= $past(on_t))
    && ($past(value) < $past(off_t))))
    else $error("decimal setting changed result");

  // ***************************************************
  // assertions on the register bus
  // ***************************************************
  // the two phases of one apb transfer
  sequence apb_setup;
    psel && !penable;
  endsequence

  sequence apb_access;
    psel && penable;
  endsequence

  // zero wait states: the answer stands in the access phase only
  ready_after_setup_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_setup |=> pready)
    else $error("pready missing in access phase");
  ready_one_cycle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held too long");
  err_with_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  // error for every offset past the status entry; none for the gain entry
  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_setup ##0 (paddr > `ATCU_OFF_STAT) |=> pslverr)
    else $error("unmapped access not flagged");
  mapped_no_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_setup ##0 (paddr == `ATCU_OFF_GAIN) |=> !pslverr)
    else $error("mapped access flagged");
  // write lands at the access edge; read data stands in access
  set_write_lands_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_access ##0 (pwrite && paddr == `ATCU_OFF_SET)
    |=> set_thr == $past(pwdata))
    else $error("set threshold write lost");
  stat_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_setup ##0 (!pwrite && paddr == `ATCU_OFF_STAT)
    |=> prdata[`ATCU_STAT_TRIG] == $past(trig_out))
    else $error("status read wrong");
endmodule : atcu_top

/* File: dv/atcu_src_model.sv */
// model of the blocks that hand analog values to the unit
// assumes the bench pulses load for one cycle with new values
`timescale 1ns/10ps
module atcu_src_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the bench
  input wire logic load,
  input wire logic [10:0] a_val,
  input wire logic [10:0] b_val,
  // values toward the unit
  output logic [10:0] first_analog_input,
  output logic [10:0] second_analog_input
);
  // held between loads, as a block output would be
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_analog_input <= 11'h000;
      second_analog_input <= 11'h000;
    end else if (load) begin
      first_analog_input <= a_val;
      second_analog_input <= b_val;
    end
  end
endmodule : atcu_src_model

/* File: dv/test_analog_threshold_compare_unit.sv */
// self-checking bench for the threshold compare unit
// assumes atcu_top with a short evaluation period and the source model
`timescale 1ns/10ps
`include "atcu_cfg.svh"
module test_analog_threshold_compare_unit;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, load = 1'b0, trig_out, eval_strobe, pready;
  logic pslverr, err, q_exp = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [10:0] a_val = 11'h000, b_val = 11'h000, ain, bin;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  int gain, zoff, thr_set, thr_clr, diff, mode;
  // ***************************************************
  // clock, design and source
  // ***************************************************
  always #12.5 pclk = ~pclk;
  atcu_top #(.CYCLE_DIV(8), .AW(11)) u_atcu_top (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_analog_input(ain),
    .second_analog_input(bin), .trig_out(trig_out),
    .eval_strobe(eval_strobe));
  atcu_src_model u_atcu_src_model (.pclk(pclk), .presetn(presetn),
    .load(load), .a_val(a_val), .b_val(b_val),
    .first_analog_input(ain), .second_analog_input(bin));
  // hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cfg(input int c, input int g, input int z, input int s,
                     input int cl, input int d);
    mode = c % 4;
    gain = g;
    zoff = z;
    thr_set = s;
    thr_clr = cl;
    diff = d;
    apb(1'b1, `ATCU_OFF_GAIN, g);
    apb(1'b1, `ATCU_OFF_ZERO, z);
    apb(1'b1, `ATCU_OFF_SET, s);
    apb(1'b1, `ATCU_OFF_CLR, cl);
    apb(1'b1, `ATCU_OFF_DIFF, d);
    apb(1'b1, `ATCU_OFF_CTRL, c);
  endtask : cfg
  function automatic int act(input int raw);
    return raw * gain / 100 + zoff;
  endfunction : act
  // new inputs, two evaluations, then the expected output level
  task automatic step(input int a, input int b);
    int v;
    int clr;
    v = (mode == 2) ? act(a) - act(b) : act(a);
    clr = (mode == 1) ? thr_set + diff : thr_clr;
    if (thr_set >= clr)
      q_exp = (v > thr_set) ? 1'b1 : (v <= clr) ? 1'b0 : q_exp;
    else
      q_exp = (v >= thr_set && v < clr);
    @(posedge pclk);
    load <= 1'b1;
    a_val <= a[10:0];
    b_val <= b[10:0];
    @(posedge pclk);
    load <= 1'b0;
    repeat (2) begin
      @(posedge pclk);
      while (eval_strobe !== 1'b1) @(posedge pclk);
    end
    #1;
    chk({31'h0, trig_out}, {31'h0, q_exp});
  endtask : step
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ATCU_OFF_GAIN, 32'h0);
    chk(rd, `ATCU_GAIN_RST);
    apb(1'b0, 12'h01C, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("reset and map done");
    cfg(0, 200, 10, 500, 300, 0);
    step(250, 0);
    apb(1'b0, `ATCU_OFF_STAT, 32'h0);
    chk(rd, 32'h0000_0001);
    step(200, 0);
    step(145, 0);
    $display("hysteresis done");
    cfg(8'h33, 100, 0, 100, 200, 0);
    step(99, 0);
    step(100, 0);
    step(199, 0);
    step(200, 0);
    apb(1'b0, `ATCU_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0033);
    $display("window done");
    cfg(1, 100, 0, 500, 0, -200);
    step(501, 0);
    step(301, 0);
    step(300, 0);
    cfg(1, 100, 0, 500, 0, 100);
    step(499, 0);
    step(500, 0);
    step(600, 0);
    $display("differential done");
    cfg(2, 200, 5, 50, 20, 0);
    step(100, 74);
    step(100, 85);
    step(100, 90);
    cfg(2, 100, 0, -10, 10, 0);
    step(100, 105);
    step(100, 90);
    $display("comparator done");
    end_sim();
  end
endmodule : test_analog_threshold_compare_unit
